/* File: rtl/scd_consts.svh */
`ifndef SCD_CONSTS_SVH
`define SCD_CONSTS_SVH

// Register byte offsets
`define SCD_OFS_CTRL        8'h00
`define SCD_OFS_STATUS      8'h04
`define SCD_ADR_BITS        8

// Control register fields
`define SCD_CTRL_RESAMPLE   0
`define SCD_CTRL_RELEASE    6

// Status register fields
`define SCD_ST_ADDR_LSB     0
`define SCD_ST_ADDR_MSB     4
`define SCD_ST_ADDR_VALID   5
`define SCD_ST_MAC_LSB      6
`define SCD_ST_MAC_MSB      8
`define SCD_ST_MAC_RSVD     9
`define SCD_ST_MASTER       10
`define SCD_ST_AUTO_DIS     11
`define SCD_ST_CLK_SEL      12
`define SCD_ST_PERMIT       13
`define SCD_ST_SAMPLING     14

// Strap modes and level counts
`define SCD_MODE_1          2'h1
`define SCD_MODE_2          2'h2
`define SCD_MODE_3          2'h3
`define SCD_LEVELS_ADDR     3
`define SCD_LEVELS_PLAIN    2
`define SCD_NUM_STRAPS      8
`define SCD_NUM_ADDR_STRAPS 2

// Strap slots
`define SCD_SLOT_RXCTRL     0
`define SCD_SLOT_RXERR      1
`define SCD_SLOT_MAC0       2
`define SCD_SLOT_MAC1       3
`define SCD_SLOT_MAC2       4
`define SCD_SLOT_RD3        5
`define SCD_SLOT_ROLE       6
`define SCD_SLOT_AUTO       7

// Management address strap codes
`define SCD_CODE_0          4'h0
`define SCD_CODE_4          4'h4
`define SCD_CODE_5          4'h5
`define SCD_CODE_8          4'h8
`define SCD_CODE_A          4'hA
`define SCD_CODE_C          4'hC
`define SCD_CODE_D          4'hD
`define SCD_CODE_E          4'hE
`define SCD_CODE_F          4'hF

// MAC select codes
`define SCD_MAC_SGMII       3'h0
`define SCD_MAC_MII         3'h1
`define SCD_MAC_RMII_S      3'h2
`define SCD_MAC_RMII_M      3'h3
`define SCD_MAC_RGMII_AL    3'h4
`define SCD_MAC_RGMII_TX    3'h5
`define SCD_MAC_RGMII_TXRX  3'h6
`define SCD_MAC_RGMII_RX    3'h7

`endif

/* File: rtl/scd_pkg.sv */
package scd_pkg;

  typedef enum logic [2:0] {
    SCD_MAC_SGMII4,
    SCD_MAC_MII,
    SCD_MAC_RMII_SLAVE,
    SCD_MAC_RMII_MASTER,
    SCD_MAC_RGMII_ALIGN,
    SCD_MAC_RGMII_TXDLY,
    SCD_MAC_RGMII_TXRXDLY,
    SCD_MAC_RGMII_RXDLY
  } scd_mac_mode_t;

  typedef logic [1:0] scd_mode_t;

endpackage : scd_pkg

/* File: rtl/scd_strap_if.sv */
`timescale 1ns/1ps
interface scd_strap_if;
  logic [1:0]        thermo;
  scd_pkg::scd_mode_t mode;
  logic              legal;

  modport dec (input thermo, output mode, output legal);
  modport top (output thermo, input mode, input legal);
endinterface : scd_strap_if

/* File: rtl/scd_level_decoder.sv */
`timescale 1ns/1ps
`include "scd_consts.svh"

// Thermometer from the strap comparators: bit0 above the low threshold,
// bit1 above the high threshold. Two-level straps only use bit0.
module scd_level_decoder #(
  parameter int LEVELS = 2
) (
  scd_strap_if.dec s
);

  always_comb begin
    s.mode  = `SCD_MODE_1;
    s.legal = 1'b1;
    if (LEVELS == `SCD_LEVELS_ADDR) begin
      unique case (s.thermo)
        2'h0: s.mode = `SCD_MODE_1;
        2'h1: s.mode = `SCD_MODE_2;
        2'h3: s.mode = `SCD_MODE_3;
        // Upper without lower cannot come from a divider; read as highest
        default: begin
          s.mode  = `SCD_MODE_3;
          s.legal = 1'b0;
        end
      endcase
    end else begin
      s.mode = s.thermo[0] ? `SCD_MODE_2 : `SCD_MODE_1;
    end
  end

endmodule : scd_level_decoder

/* File: rtl/scd_top.sv */
// Operation
// - Every strap is sampled after power-up, after the reset pin and after a resample write.
// - The two address straps decode to three modes and every other strap to two modes.
// - With clock pin select at 0 the clock leaves on the default pin and auto-disable comes from the indicator pin.
// - With clock pin select at 1 the two pins swap roles and auto-disable comes from the default clock pin.
// - Clock pin select only swaps pin functions and never moves a pin to another supply.
// - The role strap at 0 gives link slave and at 1 gives link master.
// - Auto-disable at 0 lets the link start by itself after power-up.
// - Auto-disable at 1 holds off link start until software permits it.
// - Writing one to the release bit permits link-up and the bit clears itself once link is up.
// - The three MAC select bits, MSB first, pick SGMII, MII, RMII slave/master or one of four RGMII modes.
// - The all-zero MAC code is four-wire SGMII only on the variant that has it, else reserved.
// - Both address straps in mode 1 give address 0, receive-control mode 2 or 3 alone give 0x4 or 0x5.
// - Receive-error mode 2 gives 0x8, 0xC, 0xD and mode 3 gives 0xA, 0xE, 0xF for control modes 1 to 3.
// - The seven unreachable address codes stay unassigned with no address.
// - The latched address is one of nine values and is zero with no pull-ups fitted.
`timescale 1ns/1ps
`include "scd_consts.svh"

module scd_top #(
  parameter bit SGMII_VARIANT = 1'b1
) (
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // Wishbone slave
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [31:0]           wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  // Strap comparator inputs
  input  wire logic [1:0]            receive_ctrl_strap_i,
  input  wire logic [1:0]            receive_error_strap_i,
  input  wire logic [2:0]            mac_if_select_i,
  input  wire logic                  receive_data3_strap_i,
  input  wire logic                  link_role_select_i,
  // Shared clock and indicator pins
  input  wire logic                  clock_output_pin_i,
  output logic                       clock_output_pin_o,
  output logic                       clock_output_pin_oe_o,
  input  wire logic                  second_indicator_pin_i,
  output logic                       second_indicator_pin_o,
  output logic                       second_indicator_pin_oe_o,
  // Core functional sources and link state
  input  wire logic                  ref_clk_out_i,
  input  wire logic                  indicator_i,
  input  wire logic                  link_up_i,
  // Latched configuration
  output logic                       cfg_valid_o,
  output scd_pkg::scd_mac_mode_t     mac_if_mode_o,
  output logic                       mac_reserved_o,
  output logic                       link_master_o,
  output logic                       autonomous_o,
  output logic                       link_enable_o,
  output logic [4:0]                 mgmt_address_strap_o,
  output logic                       mgmt_address_valid_o
);

  logic                   sampling_r;
  logic                   cfg_valid_r;
  logic [3:0]             addr_code;
  logic [4:0]             addr_nxt;
  logic                   addr_ok_nxt;
  logic [4:0]             addr_r;
  logic                   addr_valid_r;
  logic [2:0]             mac_code_r;
  logic                   mac_rsvd_r;
  logic                   master_r;
  logic                   clock_pin_select_r;
  logic                   auto_dis_r;
  logic                   release_r;
  logic                   permit_r;
  logic                   ack_r;
  logic [31:0]            rdata_r;
  logic                   req;
  logic                   wr_ctrl;
  logic                   resample_req;
  logic                   auto_src;
  logic [1:0]             thermo [`SCD_NUM_STRAPS];
  scd_pkg::scd_mode_t     mode   [`SCD_NUM_STRAPS];
  logic                   strap_bit [`SCD_NUM_STRAPS];
  scd_pkg::scd_mac_mode_t mac_mode_r;

  // Bus decode
  assign req     = wb_cyc_i && wb_stb_i && !ack_r;
  assign wr_ctrl = req && wb_we_i && wb_sel_i[0]
                   && (wb_adr_i[`SCD_ADR_BITS-1:0] == `SCD_OFS_CTRL);
  assign resample_req = wr_ctrl && wb_dat_i[`SCD_CTRL_RESAMPLE];

  // auto-disable source
  // Swapped source follows the clock pin strap of the same sample
  assign auto_src = strap_bit[`SCD_SLOT_RD3] ? clock_output_pin_i : second_indicator_pin_i;

  assign thermo[`SCD_SLOT_RXCTRL] = receive_ctrl_strap_i;
  assign thermo[`SCD_SLOT_RXERR]  = receive_error_strap_i;
  assign thermo[`SCD_SLOT_MAC0]   = {1'b0, mac_if_select_i[0]};
  assign thermo[`SCD_SLOT_MAC1]   = {1'b0, mac_if_select_i[1]};
  assign thermo[`SCD_SLOT_MAC2]   = {1'b0, mac_if_select_i[2]};
  assign thermo[`SCD_SLOT_RD3]    = {1'b0, receive_data3_strap_i};
  assign thermo[`SCD_SLOT_ROLE]   = {1'b0, link_role_select_i};
  assign thermo[`SCD_SLOT_AUTO]   = {1'b0, auto_src};

  generate
    for (genvar g = 0; g < `SCD_NUM_STRAPS; g++) begin : g_strap
      scd_strap_if s_if ();
      assign s_if.thermo = thermo[g];
      assign mode[g]     = s_if.mode;
      assign strap_bit[g] = (s_if.mode == `SCD_MODE_2);
      scd_level_decoder #(
        .LEVELS ((g < `SCD_NUM_ADDR_STRAPS) ? `SCD_LEVELS_ADDR : `SCD_LEVELS_PLAIN)
      ) u_dec (
        .s (s_if.dec)
      );
    end
  endgenerate

  // address bit mapping
  // Control strap drives bits 0 and 2, error strap bits 1 and 3
  always_comb begin
    addr_code = 4'h0;
    addr_code[0] = (mode[`SCD_SLOT_RXCTRL] == `SCD_MODE_3);
    addr_code[2] = (mode[`SCD_SLOT_RXCTRL] != `SCD_MODE_1);
    addr_code[1] = (mode[`SCD_SLOT_RXERR] == `SCD_MODE_3);
    addr_code[3] = (mode[`SCD_SLOT_RXERR] != `SCD_MODE_1);
  end

  always_comb begin
    addr_nxt    = 5'h00;
    addr_ok_nxt = 1'b1;
    unique case (addr_code)
      `SCD_CODE_0: addr_nxt = 5'h00;
      `SCD_CODE_4: addr_nxt = 5'h04;
      `SCD_CODE_5: addr_nxt = 5'h05;
      `SCD_CODE_8: addr_nxt = 5'h08;
      `SCD_CODE_A: addr_nxt = 5'h0A;
      `SCD_CODE_C: addr_nxt = 5'h0C;
      `SCD_CODE_D: addr_nxt = 5'h0D;
      `SCD_CODE_E: addr_nxt = 5'h0E;
      `SCD_CODE_F: addr_nxt = 5'h0F;
      default: addr_ok_nxt = 1'b0;
    endcase
  end

  // sample sequencing
  // Caught on the first edge after reset release, never under reset itself
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sampling_r  <= 1'b1;
      cfg_valid_r <= 1'b0;
    end else if (resample_req) begin
      sampling_r  <= 1'b1;
      cfg_valid_r <= 1'b0;
    end else if (sampling_r) begin
      sampling_r  <= 1'b0;
      cfg_valid_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_r             <= 5'h00;
      addr_valid_r       <= 1'b0;
      mac_code_r         <= 3'h0;
      master_r           <= 1'b0;
      clock_pin_select_r <= 1'b0;
      auto_dis_r         <= 1'b0;
    end else if (sampling_r && !resample_req) begin
      addr_r             <= addr_nxt;
      addr_valid_r       <= addr_ok_nxt;
      mac_code_r         <= {strap_bit[`SCD_SLOT_MAC2], strap_bit[`SCD_SLOT_MAC1],
                             strap_bit[`SCD_SLOT_MAC0]};
      master_r           <= strap_bit[`SCD_SLOT_ROLE];
      clock_pin_select_r <= strap_bit[`SCD_SLOT_RD3];
      auto_dis_r         <= strap_bit[`SCD_SLOT_AUTO];
    end
  end

  always_comb begin
    mac_mode_r = scd_pkg::SCD_MAC_SGMII4;
    mac_rsvd_r = 1'b0;
    unique case (mac_code_r)
      `SCD_MAC_SGMII: begin
        mac_mode_r = scd_pkg::SCD_MAC_SGMII4;
        mac_rsvd_r = !SGMII_VARIANT;
      end
      `SCD_MAC_MII:        mac_mode_r = scd_pkg::SCD_MAC_MII;
      `SCD_MAC_RMII_S:     mac_mode_r = scd_pkg::SCD_MAC_RMII_SLAVE;
      `SCD_MAC_RMII_M:     mac_mode_r = scd_pkg::SCD_MAC_RMII_MASTER;
      `SCD_MAC_RGMII_AL:   mac_mode_r = scd_pkg::SCD_MAC_RGMII_ALIGN;
      `SCD_MAC_RGMII_TX:   mac_mode_r = scd_pkg::SCD_MAC_RGMII_TXDLY;
      `SCD_MAC_RGMII_TXRX: mac_mode_r = scd_pkg::SCD_MAC_RGMII_TXRXDLY;
      `SCD_MAC_RGMII_RX:   mac_mode_r = scd_pkg::SCD_MAC_RGMII_RXDLY;
    endcase
  end

  // release bit
  // A write in the link-up cycle wins, so software never loses a release
  always_ff @(posedge clk_i) begin
    if (rst_i || resample_req) begin
      release_r <= 1'b0;
    end else if (wr_ctrl && wb_dat_i[`SCD_CTRL_RELEASE]) begin
      release_r <= 1'b1;
    end else if (link_up_i) begin
      release_r <= 1'b0;
    end
  end

  // managed hold-off
  // Permission survives the self-clear of the release bit
  always_ff @(posedge clk_i) begin
    if (rst_i || resample_req) begin
      permit_r <= 1'b0;
    end else if (release_r) begin
      permit_r <= 1'b1;
    end
  end

  assign link_enable_o = cfg_valid_r && (!auto_dis_r || permit_r);

  // function-only pin swap
  // Straps are inputs while sampling, so both drivers stay off then
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clock_output_pin_o        <= 1'b0;
      clock_output_pin_oe_o     <= 1'b0;
      second_indicator_pin_o    <= 1'b0;
      second_indicator_pin_oe_o <= 1'b0;
    end else begin
      clock_output_pin_oe_o     <= !sampling_r && !resample_req;
      second_indicator_pin_oe_o <= !sampling_r && !resample_req;
      clock_output_pin_o     <= clock_pin_select_r ? indicator_i : ref_clk_out_i;
      second_indicator_pin_o <= clock_pin_select_r ? ref_clk_out_i : indicator_i;
    end
  end

  // Wishbone answer one cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h00000000;
    end else begin
      ack_r   <= req;
      rdata_r <= 32'h00000000;
      if (req && !wb_we_i) begin
        unique case (wb_adr_i[`SCD_ADR_BITS-1:0])
          `SCD_OFS_CTRL:
            rdata_r[`SCD_CTRL_RELEASE] <= release_r;
          `SCD_OFS_STATUS: begin
            rdata_r[`SCD_ST_ADDR_MSB:`SCD_ST_ADDR_LSB] <= addr_r;
            rdata_r[`SCD_ST_ADDR_VALID]               <= addr_valid_r;
            rdata_r[`SCD_ST_MAC_MSB:`SCD_ST_MAC_LSB]   <= mac_code_r;
            rdata_r[`SCD_ST_MAC_RSVD]                 <= mac_rsvd_r;
            rdata_r[`SCD_ST_MASTER]                   <= master_r;
            rdata_r[`SCD_ST_AUTO_DIS]                 <= auto_dis_r;
            rdata_r[`SCD_ST_CLK_SEL]                  <= clock_pin_select_r;
            rdata_r[`SCD_ST_PERMIT]                   <= permit_r;
            rdata_r[`SCD_ST_SAMPLING]                 <= sampling_r;
          end
          default: rdata_r <= 32'h00000000;
        endcase
      end
    end
  end

  assign wb_ack_o             = ack_r;
  assign wb_dat_o             = rdata_r;
  assign cfg_valid_o          = cfg_valid_r;
  assign mac_if_mode_o        = mac_mode_r;
  assign mac_reserved_o       = mac_rsvd_r;
  assign link_master_o        = master_r;
  assign autonomous_o         = !auto_dis_r;
  assign mgmt_address_strap_o = addr_r;
  assign mgmt_address_valid_o = addr_valid_r;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_sample_after_rst: assert property (
    $past(rst_i) |-> sampling_r ##1 (cfg_valid_r || $past(resample_req)))
    else $error("straps not sampled after reset release");

  a_resample_write: assert property (
    resample_req |=> sampling_r && !cfg_valid_r)
    else $error("resample write did not restart sampling");

  a_pins_released: assert property (
    sampling_r |=> !clock_output_pin_oe_o && !second_indicator_pin_oe_o)
    else $error("pins driven during strap sampling");

  a_cfg_hold: assert property (
    cfg_valid_r && !resample_req |=> $stable(addr_r) && $stable(mac_code_r)
      && $stable(master_r) && $stable(auto_dis_r) && $stable(clock_pin_select_r))
    else $error("latched strap changed after sampling");

  a_pin_swap: assert property (
    cfg_valid_r && clock_pin_select_r && !resample_req
      |=> second_indicator_pin_o == $past(ref_clk_out_i)
          && clock_output_pin_o == $past(indicator_i))
    else $error("clock not on swapped pin");

  a_auto_source: assert property (
    sampling_r && !resample_req && !receive_data3_strap_i
      |=> auto_dis_r == $past(second_indicator_pin_i))
    else $error("auto-disable taken from wrong pin");

  a_role_latch: assert property (
    sampling_r && !resample_req |=> link_master_o == $past(link_role_select_i))
    else $error("link role does not follow strap");

  a_managed_hold: assert property (
    cfg_valid_r && auto_dis_r && !permit_r |-> !link_enable_o)
    else $error("link enabled in managed mode without release");

  a_release_clear: assert property (
    release_r && link_up_i && !wr_ctrl |=> !release_r ##0 permit_r)
    else $error("release bit not cleared on link up");

  a_addr_nine: assert property (
    cfg_valid_r |-> addr_valid_r && addr_r inside {5'h00, 5'h04, 5'h05, 5'h08,
      5'h0A, 5'h0C, 5'h0D, 5'h0E, 5'h0F})
    else $error("latched address outside the nine values");

  a_addr_default: assert property (
    sampling_r && !resample_req && receive_ctrl_strap_i == 2'h0
      && receive_error_strap_i == 2'h0 |=> addr_r == 5'h00)
    else $error("open straps did not give address zero");

  a_sgmii_reserved: assert property (
    mac_code_r == `SCD_MAC_SGMII |-> mac_reserved_o == !SGMII_VARIANT)
    else $error("SGMII code reserved flag wrong");

endmodule : scd_top

/* File: tb/scd_strap_model.sv */
`timescale 1ns/1ps
// Strap resistors on the two address comparator inputs and on the two shared pins
module scd_strap_model (
  // Chosen strap modes and levels
  input  wire logic [1:0] ctrl_mode_i,
  input  wire logic [1:0] err_mode_i,
  input  wire logic       clk_sel_i,
  input  wire logic       auto_dis_i,
  // Design pin drivers
  input  wire logic       clk_pin_drv_i,
  input  wire logic       clk_pin_oe_i,
  input  wire logic       ind_pin_drv_i,
  input  wire logic       ind_pin_oe_i,
  // Comparator views
  output logic [1:0]      ctrl_thermo_o,
  output logic [1:0]      err_thermo_o,
  output logic            clk_pin_o,
  output logic            ind_pin_o
);
  function automatic logic [1:0] thermo(input logic [1:0] m);
    return (m == 2'h3) ? 2'h3 : ((m == 2'h2) ? 2'h1 : 2'h0);
  endfunction : thermo

  assign ctrl_thermo_o = thermo(ctrl_mode_i);
  assign err_thermo_o  = thermo(err_mode_i);

  // auto strap placement
  // Other pin gets the inverse so a wrong source pick is visible
  assign clk_pin_o = clk_pin_oe_i ? clk_pin_drv_i : (clk_sel_i ? auto_dis_i : ~auto_dis_i);
  assign ind_pin_o = ind_pin_oe_i ? ind_pin_drv_i : (clk_sel_i ? ~auto_dis_i : auto_dis_i);
endmodule : scd_strap_model

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic                   clk_i = 1'b0;
  logic                   rst_i = 1'b1;
  logic                   wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  logic [31:0]            wb_adr = 32'h0, wb_dat = 32'h0, wb_dat_o, rd;
  logic [3:0]             wb_sel = 4'h0;
  logic                   wb_ack_o;
  logic [1:0]             ctrl_mode = 2'h1, err_mode = 2'h1, ctrl_th, err_th;
  logic [2:0]             mac = 3'h0;
  logic                   clk_sel = 1'b0, role = 1'b0, auto_dis = 1'b0;
  logic                   ref_clk = 1'b0, ind_src = 1'b0, link_up = 1'b0;
  logic                   clk_pin, ind_pin, clk_pin_o, clk_pin_oe, ind_pin_o, ind_pin_oe;
  logic                   cfg_valid, mac_rsvd, master, autonomous, link_en, addr_valid;
  logic [4:0]             addr;
  scd_pkg::scd_mac_mode_t mac_mode;
  int                     mismatches = 0;
  int                     checked = 0;
  logic [4:0]             addr_tab [9] = '{5'h00, 5'h04, 5'h05, 5'h08, 5'h0C, 5'h0D,
                                           5'h0A, 5'h0E, 5'h0F};

  always #4 clk_i = ~clk_i;

  scd_top DUT (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .receive_ctrl_strap_i(ctrl_th), .receive_error_strap_i(err_th),
    .mac_if_select_i(mac), .receive_data3_strap_i(clk_sel), .link_role_select_i(role),
    .clock_output_pin_i(clk_pin), .clock_output_pin_o(clk_pin_o),
    .clock_output_pin_oe_o(clk_pin_oe), .second_indicator_pin_i(ind_pin),
    .second_indicator_pin_o(ind_pin_o), .second_indicator_pin_oe_o(ind_pin_oe),
    .ref_clk_out_i(ref_clk), .indicator_i(ind_src), .link_up_i(link_up),
    .cfg_valid_o(cfg_valid), .mac_if_mode_o(mac_mode), .mac_reserved_o(mac_rsvd),
    .link_master_o(master), .autonomous_o(autonomous), .link_enable_o(link_en),
    .mgmt_address_strap_o(addr), .mgmt_address_valid_o(addr_valid));

  scd_strap_model straps (
    .ctrl_mode_i(ctrl_mode), .err_mode_i(err_mode), .clk_sel_i(clk_sel),
    .auto_dis_i(auto_dis), .clk_pin_drv_i(clk_pin_o), .clk_pin_oe_i(clk_pin_oe),
    .ind_pin_drv_i(ind_pin_o), .ind_pin_oe_i(ind_pin_oe), .ctrl_thermo_o(ctrl_th),
    .err_thermo_o(err_th), .clk_pin_o(clk_pin), .ind_pin_o(ind_pin));

  task automatic complete_run();
    if (mismatches == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // One classic cycle, held until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                    output logic [31:0] rdat);
    int n;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_adr <= {24'h0, adr};
    wb_dat <= wd;
    wb_sel <= 4'hF;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      mismatches++;
      complete_run();
    end
    rdat = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
  endtask : wb

  // Wait for the latch, then let the pin enables follow
  task automatic settle();
    int n;
    repeat (2) @(posedge clk_i);
    n = 0;
    while (cfg_valid !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 50) begin
      mismatches++;
      complete_run();
    end
    repeat (2) @(posedge clk_i);
    #1;
  endtask : settle

  task automatic set_straps(input int i);
    @(posedge clk_i);
    ctrl_mode <= 2'(i % 3 + 1);
    err_mode  <= 2'(i / 3 + 1);
    mac       <= 3'(7 - i);
    role      <= i[0];
    clk_sel   <= i[1];
    auto_dis  <= i[2];
    ref_clk   <= i[0];
    ind_src   <= ~i[0];
  endtask : set_straps

  task automatic check_cfg(input logic [4:0] ea, input logic [2:0] em,
                           input logic cs, input logic ro, input logic ad);
    check({27'h0, addr}, {27'h0, ea});
    check({31'h0, addr_valid}, 32'h1);
    check({31'h0, cfg_valid}, 32'h1);
    check({29'h0, mac_mode}, {29'h0, em});
    check({31'h0, mac_rsvd}, 32'h0);
    check({31'h0, master}, {31'h0, ro});
    check({30'h0, autonomous, link_en}, {30'h0, ~ad, ~ad});
    check({28'h0, clk_pin_o, clk_pin_oe, ind_pin_o, ind_pin_oe},
          cs ? {28'h0, ind_src, 1'b1, ref_clk, 1'b1}
             : {28'h0, ref_clk, 1'b1, ind_src, 1'b1});
    wb(1'b0, 8'h04, 32'h0, rd);
    check(rd, {17'h0, 2'h0, cs, ad, ro, 1'b0, em, 1'b1, ea});
  endtask : check_cfg

  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    settle();
    check_cfg(5'h00, 3'h0, 1'b0, 1'b0, 1'b0);
    for (int i = 0; i < 9; i++) begin
      set_straps(i);
      wb(1'b1, 8'h00, 32'h1, rd);
      settle();
      check_cfg(addr_tab[i], 3'(7 - i), i[1], i[0], i[2]);
      @(posedge clk_i);
      ctrl_mode <= 2'h3 - ctrl_mode;
      err_mode  <= 2'h3 - err_mode;
      mac       <= ~mac;
      role      <= ~role;
      repeat (3) @(posedge clk_i);
      #1;
      check({26'h0, master, addr}, {26'h0, i[0], addr_tab[i]});
    end
    // setup writes happen before the release
    set_straps(4);
    wb(1'b1, 8'h00, 32'h1, rd);
    settle();
    wb(1'b1, 8'h04, 32'h0, rd);
    check({31'h0, link_en}, 32'h0);
    wb(1'b1, 8'h00, 32'h40, rd);
    wb(1'b0, 8'h00, 32'h0, rd);
    check({30'h0, rd[6], link_en}, 32'h3);
    @(posedge clk_i);
    link_up <= 1'b1;
    repeat (2) @(posedge clk_i);
    wb(1'b0, 8'h00, 32'h0, rd);
    check({30'h0, rd[6], link_en}, 32'h1);
    wb(1'b0, 8'h04, 32'h0, rd);
    check({31'h0, rd[13]}, 32'h1);
    // Pin reset in mid-run relatches and drops the release
    set_straps(5);
    link_up <= 1'b0;
    rst_i   <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    settle();
    check_cfg(addr_tab[5], 3'h2, 1'b0, 1'b1, 1'b1);
    wb(1'b1, 8'h04, 32'hFFFFFFFF, rd);
    wb(1'b0, 8'h10, 32'h0, rd);
    check(rd, 32'h0);
    check_cfg(addr_tab[5], 3'h2, 1'b0, 1'b1, 1'b1);
    complete_run();
  end
endmodule : tb_top
